// >>> hw/sigma_delta_preload_interrupt.sv
/*
  Control logic of a multi-channel sigma-delta converter: per-channel
  preload delay, channel grouping, interrupt delay, result-ready and
  overflow flags and the prioritised interrupt vector word.
  Assumes the filter datapath supplies fmTick, cycleStart and convDone
  strobes synchronous to sys_clk, and a classic Wishbone master.
*/
`timescale 1ns/1ns
`default_nettype none
module sigma_delta_preload_interrupt
  import sd_ctrl_pkg::*;
(
  input  wire logic                             sys_clk,
  input  wire logic                             sys_rst,
  input  wire logic                             clkEn,
  input  wire logic                             wb_cyc_i,
  input  wire logic                             wb_stb_i,
  input  wire logic                             wb_we_i,
  input  wire logic [sd_ctrl_pkg::ADR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]                       wb_sel_i,
  input  wire logic [31:0]                      wb_dat_i,
  output var  logic [31:0]                      wb_dat_o,
  output var  logic                             wb_ack_o,
  input  wire logic                             fmTick,
  input  wire logic [sd_ctrl_pkg::NCH-1:0]      cycleStart,
  input  wire logic [sd_ctrl_pkg::NCH-1:0]      convDone,
  input  wire logic [sd_ctrl_pkg::NCH*16-1:0]   convData,
  output var  logic [sd_ctrl_pkg::NCH-1:0]      chanRun,
  output var  logic [sd_ctrl_pkg::NCH-1:0]      filterHold,
  output var  logic [sd_ctrl_pkg::NCH-1:0]      tempSelect,
  output var  logic [sd_ctrl_pkg::NCH*3-1:0]    inputSelect,
  output var  logic [sd_ctrl_pkg::NCH*3-1:0]    gainSelect,
  output var  logic                             irq
);
  import sd_ctrl_pkg::*;

  // ==========================================================================
  // State
  logic                 global_interrupt_enable, ovie;
  logic [NCH-1:0]       grp, start, ifg, ie, ovf, unread, prePend;
  logic [2:0]           gain    [NCH];
  logic [2:0]           inch    [NCH];
  logic [2:0]           dlySel  [NCH];
  logic [2:0]           dlyCnt  [NCH];
  logic [RES_W-1:0]     result  [NCH];
  logic [PRE_W-1:0]     preload [NCH];
  logic [PRE_W-1:0]     holdCnt [NCH];
  logic [4:0]           vector;
  logic                 next_gie, next_ovie, next_irq, next_ack;
  logic [NCH-1:0]       next_grp, next_start, next_ifg, next_ie, next_ovf;
  logic [NCH-1:0]       next_unread, next_prePend, next_hold, next_temp;
  logic [2:0]           next_gain    [NCH];
  logic [2:0]           next_inch    [NCH];
  logic [2:0]           next_dlySel  [NCH];
  logic [2:0]           next_dlyCnt  [NCH];
  logic [RES_W-1:0]     next_result  [NCH];
  logic [PRE_W-1:0]     next_preload [NCH];
  logic [PRE_W-1:0]     next_holdCnt [NCH];
  logic [4:0]           next_vector;
  logic [31:0]          next_rdData;

  // ==========================================================================
  // Bus decode
  logic [5:0]  idx;
  logic [3:0]  chField;
  logic [1:0]  chIdx;
  logic        chHit, take;
  logic [31:0] regView, byteMask, merged;

  assign idx      = wb_adr_i[7:2];
  assign chField  = idx[5:2];
  assign chIdx    = 2'(chField - 4'h1);
  assign chHit    = (chField >= 4'h1) && (chField <= 4'(NCH))
                    && (idx[1:0] != 2'h3);
  assign take     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign byteMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign merged   = (regView & ~byteMask) | (wb_dat_i & byteMask);

  // Current contents of the addressed register; unmapped reads give zero.
  always_comb begin
    regView = RST_WORD;
    if (idx == IDX_GCTRL) begin
      regView[GC_GIE]  = global_interrupt_enable;
      regView[GC_OVIE] = ovie;
    end else if (idx == IDX_IVEC) begin
      regView[4:0] = vector;
    end else if (chHit) begin
      unique case (idx[1:0])
        SUB_CCTL: begin
          regView[CC_GRP]          = grp[chIdx];
          regView[CC_START]        = start[chIdx];
          regView[CC_IFG]          = ifg[chIdx];
          regView[CC_IE]           = ie[chIdx];
          regView[CC_OVF]          = ovf[chIdx];
          regView[CC_GAIN+:3]      = gain[chIdx];
          regView[CC_INCH+:3]      = inch[chIdx];
          regView[CC_DLY+:3]       = dlySel[chIdx];
        end
        SUB_RESULT:  regView[RES_W-1:0] = result[chIdx];
        SUB_PRELOAD: regView[PRE_W-1:0] = preload[chIdx];
        default:     regView = RST_WORD;
      endcase
    end
  end

  // ==========================================================================
  // Next-state logic. Order matters: software effects first, then group
  // propagation, then hardware events, so a hardware set beats a clear
  // that lands in the same cycle.
  always_comb begin
    logic         mWrite;
    logic [1:0]   mChan;
    logic [1:0]   master [NCH];
    logic         found;
    mWrite = 1'b0;
    mChan  = 2'h0;
    found  = 1'b0;
    master = '{default: 2'h0};
    next_gie     = global_interrupt_enable;
    next_ovie    = ovie;
    next_grp     = grp;
    next_start   = start;
    next_ifg     = ifg;
    next_ie      = ie;
    next_ovf     = ovf;
    next_unread  = unread;
    next_prePend = prePend;
    next_gain    = gain;
    next_inch    = inch;
    next_dlySel  = dlySel;
    next_dlyCnt  = dlyCnt;
    next_result  = result;
    next_preload = preload;
    next_holdCnt = holdCnt;
    next_ack     = take;
    next_rdData  = (take && !wb_we_i) ? regView : RST_WORD;

    // Master of each channel: first channel at or above it with group clear.
    for (int c = 0; c < NCH; c++) begin
      master[c] = 2'(NCH - 1);
      found     = 1'b0;
      for (int m = c; m < NCH; m++) begin
        if (!found && !grp[m]) begin
          master[c] = 2'(m);
          found     = 1'b1;
        end
      end
    end

    // Software accesses. The vector word is read-only and side-effect free.
    if (take && wb_we_i) begin
      if (idx == IDX_GCTRL) begin
        next_gie  = merged[GC_GIE];
        next_ovie = merged[GC_OVIE];
      end else if (chHit && idx[1:0] == SUB_CCTL) begin
        // The last channel cannot group with a channel that does not exist.
        next_grp[chIdx]    = merged[CC_GRP] && (chIdx != 2'(NCH - 1));
        next_start[chIdx]  = merged[CC_START];
        next_ifg[chIdx]    = merged[CC_IFG];
        next_ie[chIdx]     = merged[CC_IE];
        next_ovf[chIdx]    = merged[CC_OVF];
        next_gain[chIdx]   = merged[CC_GAIN+:3];
        next_inch[chIdx]   = merged[CC_INCH+:3];
        next_dlySel[chIdx] = merged[CC_DLY+:3];
        mWrite = (master[chIdx] == chIdx) && (start[chIdx] != merged[CC_START]);
        mChan  = chIdx;
      end else if (chHit && idx[1:0] == SUB_PRELOAD) begin
        next_preload[chIdx] = merged[PRE_W-1:0];
        next_prePend[chIdx] = 1'b1;
      end
    end else if (take && chHit && idx[1:0] == SUB_RESULT) begin
      next_ifg[chIdx]    = 1'b0;
      next_unread[chIdx] = 1'b0;
    end

    // A master start change is copied to every channel of its group.
    for (int c = 0; c < NCH; c++) begin
      if (mWrite && master[c] == mChan && 2'(c) != mChan) begin
        next_start[c] = next_start[mChan];
      end
    end

    for (int c = 0; c < NCH; c++) begin
      // Start rising, also a grouped channel rejoining its master, re-arms
      // both the preload and the interrupt delay.
      if (next_start[c] && !start[c]) begin
        next_prePend[c] = 1'b1;
        next_dlyCnt[c]  = (next_dlySel[c] > DLY_MAX) ? DLY_MAX
                                                     : next_dlySel[c];
      end
      if (next_gain[c] != gain[c] || next_inch[c] != inch[c]) begin
        next_dlyCnt[c] = (next_dlySel[c] > DLY_MAX) ? DLY_MAX
                                                    : next_dlySel[c];
      end

      // The stored preload is sampled only at a cycle start, so a write
      // lands on the following cycle and never on the one running.
      if (!start[c]) begin
        next_holdCnt[c] = '0;
      end else if (cycleStart[c] && prePend[c]) begin
        next_holdCnt[c] = preload[c];
        next_prePend[c] = next_prePend[c] && (next_preload[c] != preload[c]);
      end else if (fmTick && holdCnt[c] != '0) begin
        next_holdCnt[c] = holdCnt[c] - 8'h01;
      end

      // Results of a started channel are always stored; flags are withheld while delaying.
      if (convDone[c] && start[c]) begin
        next_result[c] = convData[c*RES_W +: RES_W];
        if (dlyCnt[c] != 3'h0) begin
          next_dlyCnt[c] = next_dlyCnt[c] - 3'h1;
        end else begin
          next_ifg[c]    = 1'b1;
          next_ovf[c]    = next_ovf[c] || unread[c];
          next_unread[c] = 1'b1;
        end
      end
      next_hold[c] = next_holdCnt[c] != '0;
      next_temp[c] = next_inch[c] == INCH_TEMP;
    end

    // Priority: overflow, then result flags from channel zero upward.
    next_vector = VEC_NONE;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (next_ifg[c] && next_ie[c]) begin
        next_vector = 5'(VEC_CH0 + 5'(2 * c));
      end
    end
    if (next_ovie && next_ovf != '0) begin
      next_vector = VEC_OVF;
    end
    next_irq = next_gie && (next_vector != VEC_NONE);
  end

  // ==========================================================================
  // Registers. clkEn freezes every flip-flop, bus answer included.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      global_interrupt_enable        <= 1'b0;
      ovie       <= 1'b0;
      grp        <= '0;
      start      <= '0;
      ifg        <= '0;
      ie         <= '0;
      ovf        <= '0;
      unread     <= '0;
      prePend    <= '0;
      filterHold <= '0;
      tempSelect <= '0;
      vector     <= VEC_NONE;
      irq        <= 1'b0;
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= RST_WORD;
      for (int c = 0; c < NCH; c++) begin
        gain[c]    <= '0;
        inch[c]    <= '0;
        dlySel[c]  <= '0;
        dlyCnt[c]  <= '0;
        result[c]  <= '0;
        preload[c] <= '0;
        holdCnt[c] <= '0;
      end
    end else if (clkEn) begin
      global_interrupt_enable        <= next_gie;
      ovie       <= next_ovie;
      grp        <= next_grp;
      start      <= next_start;
      ifg        <= next_ifg;
      ie         <= next_ie;
      ovf        <= next_ovf;
      unread     <= next_unread;
      prePend    <= next_prePend;
      filterHold <= next_hold;
      tempSelect <= next_temp;
      vector     <= next_vector;
      irq        <= next_irq;
      wb_ack_o   <= next_ack;
      wb_dat_o   <= next_rdData;
      gain       <= next_gain;
      inch       <= next_inch;
      dlySel     <= next_dlySel;
      dlyCnt     <= next_dlyCnt;
      result     <= next_result;
      preload    <= next_preload;
      holdCnt    <= next_holdCnt;
    end
  end

  // Per-channel settings leave the block straight from their flip-flops.
  assign chanRun = start;
  for (genvar g = 0; g < NCH; g++) begin : g_out
    assign inputSelect[g*3 +: 3] = inch[g];
    assign gainSelect[g*3 +: 3]  = gain[g];
  end

  // ==========================================================================
  // Checks
  logic ivecTake;
  assign ivecTake = take && idx == IDX_IVEC && clkEn;

  vec_access_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ivecTake && convDone == '0 |=> ifg == $past(ifg) && ovf == $past(ovf))
    else $error("Vector access changed a flag.");

  irq_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    irq |-> global_interrupt_enable && vector != VEC_NONE)
    else $error("Request without enable or source.");

  ovf_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ovie && ovf != '0 |-> vector == VEC_OVF)
    else $error("Overflow not on top.");

  ch0_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !(ovie && ovf != '0) && ifg[0] && ie[0] |-> vector == VEC_CH0)
    else $error("Channel zero not on top.");

  vec_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ovf == '0 || !ovie) && (ifg & ie) == '0 |-> vector == VEC_NONE)
    else $error("Vector set with nothing pending.");

  ovf_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clkEn && convDone[0] && start[0] && dlyCnt[0] == 3'h0 && unread[0]
    |=> ovf[0])
    else $error("Overwrite gave no overflow.");

  delay_quiet_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clkEn && convDone[0] && start[0] && dlyCnt[0] != 3'h0 && !ifg[0]
    && !take |=> !ifg[0] && dlyCnt[0] == $past(dlyCnt[0]) - 3'h1)
    else $error("Delayed conversion flagged.");

  preload_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clkEn && start[0] && cycleStart[0] && prePend[0]
    |=> holdCnt[0] == $past(preload[0]) && filterHold[0] == (holdCnt[0] != 0))
    else $error("Preload not loaded at cycle start.");

  temp_sel_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tempSelect[0] == (inch[0] == INCH_TEMP))
    else $error("Temperature route wrong.");

endmodule // sigma_delta_preload_interrupt
`default_nettype wire

// >>> hw/sd_ctrl_pkg.sv
/*
  Shared constants for the sigma-delta converter control block: register
  word offsets, field positions, reset values and encodings.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package sd_ctrl_pkg;
  // ==========================================================================
  // Sizes
  localparam int          NCH         = 3;
  localparam int          RES_W       = 16;
  localparam int          PRE_W       = 8;
  localparam int          ADR_W       = 8;
  // ==========================================================================
  // Register word indices (byte address is four times the index)
  localparam logic [5:0]  IDX_GCTRL   = 6'h00;
  localparam logic [5:0]  IDX_IVEC    = 6'h01;
  localparam logic [1:0]  SUB_CCTL    = 2'h0;
  localparam logic [1:0]  SUB_RESULT  = 2'h1;
  localparam logic [1:0]  SUB_PRELOAD = 2'h2;
  // ==========================================================================
  // Field positions
  localparam int          GC_GIE      = 0;
  localparam int          GC_OVIE     = 1;
  localparam int          CC_GRP      = 0;
  localparam int          CC_START    = 1;
  localparam int          CC_IFG      = 2;
  localparam int          CC_IE       = 3;
  localparam int          CC_OVF      = 4;
  localparam int          CC_GAIN     = 8;
  localparam int          CC_INCH     = 12;
  localparam int          CC_DLY      = 16;
  // ==========================================================================
  // Encodings and reset values
  localparam logic [2:0]  INCH_TEMP   = 3'h6;
  localparam logic [2:0]  DLY_MAX     = 3'h4;
  localparam logic [4:0]  VEC_NONE    = 5'h00;
  localparam logic [4:0]  VEC_OVF     = 5'h02;
  localparam logic [4:0]  VEC_CH0     = 5'h04;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
endpackage

// >>> bench/sigma_delta_preload_interrupt_tb_top.sv
/*
  Self-checking bench for the sigma-delta converter control block.
  Assumes the design package and module of hw/ are compiled first; the
  bench plays both the bus master and the filter datapath strobes.
*/
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Comparison macro: counts every compare and reports a mismatch at once.
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  miscompares++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module sigma_delta_preload_interrupt_tb_top;
  import sd_ctrl_pkg::*;
  typedef struct {logic [31:0] e; logic [31:0] m;} note_s;
  localparam logic [7:0] gcAdr = {IDX_GCTRL, 2'b00};
  localparam logic [7:0] ivAdr = {IDX_IVEC, 2'b00};
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic        wb_ack_o, fmTick = 1'b0, irq;
  logic [2:0]  cycleStart = '0, convDone = '0;
  logic [47:0] convData = '0;
  logic [2:0]  chanRun, filterHold, tempSelect;
  logic [8:0]  inputSelect, gainSelect;
  logic [15:0] last [3];
  int          miscompares = 0, comparisons = 0, cycles = 0, pre;
  note_s       notes[$], note;
  // Clock enable is held high: freezing is not part of these scenarios.
  sigma_delta_preload_interrupt dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .clkEn(1'b1), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .fmTick(fmTick), .cycleStart(cycleStart), .convDone(convDone),
    .convData(convData), .chanRun(chanRun), .filterHold(filterHold),
    .tempSelect(tempSelect), .inputSelect(inputSelect),
    .gainSelect(gainSelect), .irq(irq));
  // ==========================================================================
  // Clock, and a cycle ceiling so that a lost acknowledge cannot hang the run.
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  // Read data is taken at the rising edge that shows ack high, before that
  // edge's own updates land, so the value seen is the one that stood.
  always @(posedge sys_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && notes.size() > 0) begin
      note = notes.pop_front();
      `CHK("readData", note.e, wb_dat_o & note.m)
    end
  end
  // ==========================================================================
  // Bus and datapath tasks.
  // The request is held until ack is seen high at a rising edge, then dropped.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffff_ffff);
    notes.push_back('{e, m});
    bus(1'b0, a, 32'h0);
  endtask
  function automatic logic [7:0] ca(input int c, input logic [1:0] s);
    return 8'(8'h10 + 16 * c + 4 * s);
  endfunction
  // One conversion-done pulse with fresh random results on the chosen lanes.
  task automatic conv(input logic [2:0] m);
    @(posedge sys_clk);
    for (int c = 0; c < NCH; c++) if (m[c]) last[c] = 16'($urandom);
    convDone <= m;
    convData <= {last[2], last[1], last[0]};
    @(posedge sys_clk);
    convDone <= 3'h0;
  endtask
  task automatic tick();
    @(posedge sys_clk);
    fmTick <= 1'b1;
    @(posedge sys_clk);
    fmTick <= 1'b0;
  endtask
  // Start a channel 0 cycle; when a preload is due, it must last pre ticks.
  task automatic hold(input logic on);
    @(posedge sys_clk);
    cycleStart <= 3'h1;
    @(posedge sys_clk);
    cycleStart <= 3'h0;
    @(negedge sys_clk);
    `CHK("filterHold", on, filterHold[0])
    if (on) begin
      repeat (pre - 1) tick();
      @(negedge sys_clk);
      `CHK("holdLength", 1'b1, filterHold[0])
      tick();
      repeat (2) @(posedge sys_clk);
      `CHK("holdEnd", 1'b0, filterHold[0])
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence.
  initial begin
    void'($urandom(15));
    for (int c = 0; c < 3; c++) last[c] = 16'h0;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(gcAdr, RST_WORD);
    rd(ivAdr, {27'h0, VEC_NONE});
    rd(ca(0, SUB_CCTL), RST_WORD);
    wr(8'hf0, 32'hffff_ffff);
    rd(8'hf0, 32'h0);
    // A result sets the ready flag; vector accesses leave flags alone.
    wr(gcAdr, 32'h3);
    wr(ca(0, SUB_CCTL), 32'h0a);
    conv(3'h1);
    rd(ca(0, SUB_CCTL), 32'h04, 32'h14);
    rd(ivAdr, {27'h0, VEC_CH0});
    wr(ivAdr, 32'h0);
    rd(ivAdr, {27'h0, VEC_CH0});
    rd(ca(0, SUB_CCTL), 32'h04, 32'h14);
    `CHK("irq", 1'b1, irq)
    // An unread result overwritten raises overflow, which outranks results.
    conv(3'h1);
    rd(ivAdr, {27'h0, VEC_OVF});
    rd(ca(0, SUB_RESULT), {16'h0, last[0]});
    rd(ca(0, SUB_CCTL), 32'h10, 32'h14);
    rd(ivAdr, {27'h0, VEC_OVF});
    wr(ca(0, SUB_CCTL), 32'h0a);
    rd(ivAdr, {27'h0, VEC_NONE});
    // Two channels pending: lower number first, the other follows.
    wr(ca(1, SUB_CCTL), 32'h0a);
    conv(3'h3);
    rd(ivAdr, {27'h0, VEC_CH0});
    rd(ca(0, SUB_RESULT), {16'h0, last[0]});
    rd(ivAdr, {27'h0, VEC_CH0 + 5'h2});
    `CHK("irq", 1'b1, irq)
    rd(ca(1, SUB_RESULT), {16'h0, last[1]});
    // Disabled sources stay out of the vector; no request without global.
    wr(ca(1, SUB_CCTL), 32'h02);
    conv(3'h2);
    rd(ivAdr, {27'h0, VEC_NONE});
    wr(gcAdr, 32'h2);
    wr(ca(1, SUB_CCTL), 32'h0e);
    rd(ivAdr, {27'h0, VEC_CH0 + 5'h2});
    `CHK("irq", 1'b0, irq)
    rd(ca(1, SUB_RESULT), {16'h0, last[1]});
    wr(gcAdr, 32'h3);
    // Delay of two conversions, restarted by start, gain and input select.
    for (int r = 0; r < 3; r++) begin
      wr(ca(2, SUB_CCTL), r == 0 ? 32'h0002_000a :
                          r == 1 ? 32'h0002_010a : 32'h0002_610a);
      for (int i = 0; i < 3; i++) begin
        conv(3'h4);
        rd(ivAdr, {27'h0, i == 2 ? VEC_CH0 + 5'h4 : VEC_NONE});
        rd(ca(2, SUB_RESULT), {16'h0, last[2]});
      end
    end
    `CHK("tempSelect", 3'h4, tempSelect)
    `CHK("inputSelect", INCH_TEMP, inputSelect[8:6])
    `CHK("gainSelect", 3'h1, gainSelect[8:6])
    // Grouped preload: once after start, not after, again on re-enable.
    wr(ca(0, SUB_CCTL), 32'h0);
    wr(ca(1, SUB_CCTL), 32'h0);
    pre = 2 + int'($urandom % 254);
    wr(ca(0, SUB_PRELOAD), 32'(pre));
    rd(ca(0, SUB_PRELOAD), 32'(pre));
    rd(ca(1, SUB_PRELOAD), 32'h0);
    wr(ca(0, SUB_CCTL), 32'h01);
    wr(ca(1, SUB_CCTL), 32'h02);
    `CHK("chanRun", 2'h3, chanRun[1:0])
    hold(1'b1);
    hold(1'b0);
    wr(ca(1, SUB_CCTL), 32'h0);
    `CHK("chanRun", 2'h0, chanRun[1:0])
    wr(ca(1, SUB_CCTL), 32'h02);
    hold(1'b1);
    end_of_test();
  end
endmodule // sigma_delta_preload_interrupt_tb_top
`default_nettype wire
